// ==== src/mif_pkg.sv ====
// Notes on behaviour
// - Each monitored internal event sets a flag bit high; sag and missing zero crossings share bit 1.
// - The interrupt request output goes low while any set flag other than bit 6 is enabled.
// - Flags are read at index 04h and a clearing view of them at index 05h.
// - Bit 0 sets when the energy register MSB rises from zero to one.
// - Bit 1 sets on a line voltage sag or on missing zero crossings.
// - Bit 2 sets when accumulation over the set half-cycle count ends.
// - Bit 3 sets whenever a new waveform sample is loaded.
// - Bit 4 follows the zero-crossing output level.
// - Bit 5 sets when a new temperature result is stored.
// - Bit 6 sets at the end of any reset and never raises the request.
// - Bit 7 sets when the energy register overflows.
// - Enable bits sit at the same positions as the flags they gate.
package mif_pkg;
   // ****************************************
   // register map (index, byte address = 4 x index)
   // ****************************************
   localparam logic [7:0] MIF_IDX_FLAGS = 8'h04;
   localparam logic [7:0] MIF_IDX_FLAGS_CLR = 8'h05;
   localparam logic [7:0] MIF_IDX_ENABLE = 8'h06;
   localparam logic [7:0] MIF_IDX_SWRESET = 8'h07;
   // ****************************************
   // flag positions
   // ****************************************
   localparam int MIF_BIT_ENERGY_HALF = 0;
   localparam int MIF_BIT_SAG = 1;
   localparam int MIF_BIT_CYCLE_DONE = 2;
   localparam int MIF_BIT_WAVE = 3;
   localparam int MIF_BIT_ZERO_CROSS = 4;
   localparam int MIF_BIT_TEMP = 5;
   localparam int MIF_BIT_RESET = 6;
   localparam int MIF_BIT_OVERFLOW = 7;
   localparam int MIF_NUM_FLAGS = 8;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] MIF_FLAGS_RST = 8'h00;
   localparam logic [7:0] MIF_ENABLE_RST = 8'h00;
   localparam logic [7:0] MIF_SETTLE_CYCLES = 8'h04;
endpackage

// ==== src/mif_sync.sv ====
`timescale 1ns/1ns
module mif_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1_q;
   // first stage feeds only the second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage1_q <= '0;
         dout <= '0;
      end else begin
         stage1_q <= din;
         dout <= stage1_q;
      end
   end
endmodule

// ==== src/metering_interrupt_flags.sv ====
`timescale 1ns/1ns
module metering_interrupt_flags (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic energyMsb,
   input wire logic sagEvent,
   input wire logic noZeroCross,
   input wire logic lineCycleDone,
   input wire logic waveSampleLoaded,
   input wire logic zeroCrossOut,
   input wire logic tempResultReady,
   input wire logic energyOverflow,
   output logic irqN,
   output logic softResetPulse
);
   // ****************************************
   // event input synchronisation
   // ****************************************
   localparam int NF = mif_pkg::MIF_NUM_FLAGS;
   logic [NF:0] rawIn;
   logic [NF:0] syncIn;
   logic [NF-1:0] evIn;
   // the two sag sources merge only after both are synchronised,
   // so no gate ever sees an unsynchronised pin
   assign rawIn = {noZeroCross, energyOverflow, 1'b0, tempResultReady,
                   zeroCrossOut, waveSampleLoaded, lineCycleDone, sagEvent,
                   energyMsb};

   mif_sync #(.WIDTH(NF + 1)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din(rawIn),
      .dout(syncIn)
   );
   assign evIn = {syncIn[NF-1:2], syncIn[1] | syncIn[NF], syncIn[0]};

   // ****************************************
   // edge detection of event strobes
   // ****************************************
   logic [7:0] prevIn_q;
   logic [7:0] rise;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prevIn_q <= 8'h00;
      end else begin
         prevIn_q <= evIn;
      end
   end
   // events other than zero-cross are taken as rising edges; level inputs would otherwise re-set
   // a flag right after software clears it
   assign rise = evIn & ~prevIn_q;

   // ****************************************
   // apb decode
   // ****************************************
   logic [9:0] wordIdx;
   logic access;
   logic hitFlags;
   logic hitClear;
   logic hitEnable;
   logic hitSwReset;
   logic mapped;
   assign wordIdx = paddr[11:2];
   assign access = psel & penable & pready;
   assign hitFlags = wordIdx == {2'b00, mif_pkg::MIF_IDX_FLAGS};
   assign hitClear = wordIdx == {2'b00, mif_pkg::MIF_IDX_FLAGS_CLR};
   assign hitEnable = wordIdx == {2'b00, mif_pkg::MIF_IDX_ENABLE};
   assign hitSwReset = wordIdx == {2'b00, mif_pkg::MIF_IDX_SWRESET};
   assign mapped = hitFlags | hitClear | hitEnable | hitSwReset;

   // ****************************************
   // software reset and reset-done marker
   // ****************************************
   logic swResetReq;
   logic [7:0] settle_q;
   logic resetDone;
   assign swResetReq = access & pwrite & hitSwReset & pwdata[0];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         softResetPulse <= 1'b0;
      end else begin
         softResetPulse <= swResetReq;
      end
   end

   // counts down after either reset; done marks the reset end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         settle_q <= mif_pkg::MIF_SETTLE_CYCLES;
      end else if (swResetReq) begin
         settle_q <= mif_pkg::MIF_SETTLE_CYCLES;
      end else if (settle_q != 8'h00) begin
         settle_q <= settle_q - 8'h01;
      end
   end
   assign resetDone = settle_q == 8'h01;

   // ****************************************
   // flag and enable registers
   // ****************************************
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] enable_q;
   logic [7:0] setVec;
   logic clearAll;

   always_comb begin
      setVec = rise;
      setVec[mif_pkg::MIF_BIT_ENERGY_HALF] =
         rise[mif_pkg::MIF_BIT_ENERGY_HALF];
      setVec[mif_pkg::MIF_BIT_SAG] = rise[mif_pkg::MIF_BIT_SAG];
      setVec[mif_pkg::MIF_BIT_CYCLE_DONE] =
         rise[mif_pkg::MIF_BIT_CYCLE_DONE];
      setVec[mif_pkg::MIF_BIT_WAVE] = rise[mif_pkg::MIF_BIT_WAVE];
      setVec[mif_pkg::MIF_BIT_TEMP] = rise[mif_pkg::MIF_BIT_TEMP];
      setVec[mif_pkg::MIF_BIT_RESET] = resetDone;
      setVec[mif_pkg::MIF_BIT_OVERFLOW] =
         rise[mif_pkg::MIF_BIT_OVERFLOW];
   end

   assign clearAll = access & ~pwrite & hitClear;

   always_comb begin
      flags_d = flags_q;
      // drop only the bits the read returned: a flag set after the data
      // was captured must survive the clear
      if (clearAll) begin
         flags_d = flags_q & ~prdata[7:0];
      end
      // a new event in the clearing cycle survives
      flags_d = flags_d | setVec;
      // zero-cross bit is a live copy, not sticky
      flags_d[mif_pkg::MIF_BIT_ZERO_CROSS] =
         evIn[mif_pkg::MIF_BIT_ZERO_CROSS];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_q <= mif_pkg::MIF_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_q <= mif_pkg::MIF_ENABLE_RST;
      end else if (access & pwrite & hitEnable) begin
         enable_q <= pwdata[7:0];
      end
   end

   // ****************************************
   // interrupt request
   // ****************************************
   logic [7:0] gated;
   always_comb begin
      gated = flags_d & enable_q;
      gated[mif_pkg::MIF_BIT_RESET] = 1'b0;
   end

   // registered from next-state so it tracks flags_q in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irqN <= 1'b1;
      end else if (access & pwrite & hitEnable) begin
         irqN <= ~|(flags_d & pwdata[7:0] &
                    ~(8'h01 << mif_pkg::MIF_BIT_RESET));
      end else begin
         irqN <= ~|gated;
      end
   end

   // ****************************************
   // apb slave response
   // ****************************************
   // no wait state: pready rises in the first access cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         if (hitFlags | hitClear) begin
            prdata <= {24'h000000, flags_q};
         end else if (hitEnable) begin
            prdata <= {24'h000000, enable_q};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
   // note: read data is captured in setup; the clearing read drops only
   // those bits, so a flag set later waits for the next read
   // host is expected to read status first when servicing
endmodule

// ==== tb/mif_properties.sv ====
`timescale 1ns/1ns
module mif_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irqN,
   input wire logic softResetPulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic enSeen_q;
   logic [9:0] idx;
   logic mapped;
   assign idx = paddr[11:2];
   assign mapped = idx >= 10'h004 && idx <= 10'h007;
   // the reset-done bit is left out: its enable must never count
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enSeen_q <= 1'b0;
      end else if (psel && penable && pready && pwrite && idx == 10'h006
                   && (pwdata[7:0] & 8'hbf) != 8'h00) begin
         enSeen_q <= 1'b1;
      end
   end
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   sequence refused_s;
      access_s ##0 !mapped;
   endsequence
   // prdata only moves on reads, so the zero check applies to reads
   sequence refused_rd_s;
      refused_s ##0 !pwrite;
   endsequence
   sequence accepted_s;
      access_s ##0 mapped;
   endsequence
   sequence reset_write_s;
      access_s ##0 (pwrite && idx == 10'h007 && pwdata[0]);
   endsequence
   answer_next_a: assert property (setup_s |=> access_s)
      else $error("no answer");
   ready_pulse_a: assert property (access_s |=> !pready)
      else $error("ready held");
   unmapped_err_a: assert property (refused_s |-> pslverr)
      else $error("unmapped not refused");
   unmapped_zero_a: assert property (refused_rd_s |-> prdata == 32'h0)
      else $error("unmapped read data");
   mapped_ok_a: assert property (accepted_s |-> !pslverr)
      else $error("bad error");
   upper_zero_a: assert property (access_s |-> prdata[31:8] == 24'h0)
      else $error("upper bits");
   masked_quiet_a: assert property (!enSeen_q |-> irqN)
      else $error("irq without enable");
   soft_reset_a: assert property (reset_write_s |=> softResetPulse)
      else $error("no reset pulse");
   pulse_once_a: assert property (softResetPulse |=> !softResetPulse)
      else $error("long pulse");
endmodule
bind metering_interrupt_flags mif_properties mif_properties_i (
   .core_clk(core_clk),
   .rst(rst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .irqN(irqN),
   .softResetPulse(softResetPulse)
);

// ==== tb/mif_host.sv ====
`timescale 1ns/1ns
module mif_host (
   input wire logic core_clk,
   input wire logic pready,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // bounded wait: a slave that never answers is reported, not waited on
   task automatic xfer(input logic wr, input logic [7:0] idx,
                       input logic [31:0] d, output bit to);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!pready && n < 16);
      to = !pready;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== tb/test_metering_interrupt_flags.sv ====
`timescale 1ns/1ns
module test_metering_interrupt_flags;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irqN;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] ev = 8'h00;
   logic [8:0] expQ[$];
   bit to;
   int fails = 0;
   int check_count = 0;
   always #2 core_clk = ~core_clk;
   mif_host mif_host_i (.core_clk(core_clk), .pready(pready), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   metering_interrupt_flags metering_interrupt_flags_i (.core_clk(core_clk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .energyMsb(ev[0]), .sagEvent(ev[1]),
      .noZeroCross(ev[6]), .lineCycleDone(ev[2]), .waveSampleLoaded(ev[3]),
      .zeroCrossOut(ev[4]), .tempResultReady(ev[5]),
      .energyOverflow(ev[7]), .irqN(irqN), .softResetPulse());
   task chk(input logic [8:0] e, input logic [8:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite) begin
         chk(expQ.pop_front(), {pslverr, prdata[7:0]});
      end
   end
   // expected read result is {error, data}; writes expect nothing
   task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
            input logic [8:0] e);
      if (!wr) expQ.push_back(e);
      mif_host_i.xfer(wr, idx, d, to);
      // a transfer that never got an answer ends the run
      if (to) begin
         fails++;
         summarize();
      end
   endtask
   task summarize;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      summarize();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      int k, b;
      logic [7:0] en;
      logic [8:0] e9;
      void'($urandom(95670));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      bus(1'b1, 8'h06, 32'h40, 9'h0);
      repeat (4) @(posedge core_clk);
      bus(1'b0, 8'h06, 32'h0, 9'h040);
      bus(1'b0, 8'h04, 32'h0, 9'h040);
      chk(9'h001, {8'h0, irqN});
      bus(1'b0, 8'h05, 32'h0, 9'h040);
      bus(1'b0, 8'h04, 32'h0, 9'h000);
      bus(1'b0, 8'h03, 32'h0, 9'h100);
      $display("test reset and map done");
      for (k = 0; k < 8; k++) begin
         b = (k == 6) ? 1 : k;
         ev[k] <= 1'b1;
         repeat (5) @(posedge core_clk);
         e9 = {1'b0, 8'h01 << b};
         bus(1'b0, 8'h05, 32'h0, e9);
         ev[k] <= 1'b0;
         repeat (5) @(posedge core_clk);
         bus(1'b0, 8'h04, 32'h0, 9'h000);
      end
      $display("test event flags done");
      for (int i = 0; i < 8; i++) begin
         en = 8'($urandom);
         k = $urandom_range(7, 0);
         b = (k == 6) ? 1 : k;
         bus(1'b1, 8'h06, {24'h0, en}, 9'h0);
         ev[k] <= 1'b1;
         repeat (5) @(posedge core_clk);
         chk({8'h0, !en[b]}, {8'h0, irqN});
         bus(1'b0, 8'h04, 32'h0, {1'b0, 8'h01 << b});
         ev[k] <= 1'b0;
         repeat (5) @(posedge core_clk);
         e9 = (k == 4) ? 9'h000 : {1'b0, 8'h01 << b};
         bus(1'b0, 8'h05, 32'h0, e9);
         repeat (3) @(posedge core_clk);
         chk(9'h001, {8'h0, irqN});
      end
      $display("test interrupt done");
      // the flag sets at the setup edge of the clearing read, after its
      // data was captured: it must outlive that read
      ev[3] <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, 8'h05, 32'h0, 9'h000);
      ev[3] <= 1'b0;
      bus(1'b0, 8'h04, 32'h0, 9'h008);
      bus(1'b0, 8'h05, 32'h0, 9'h008);
      $display("test clear race done");
      bus(1'b1, 8'h06, 32'hff, 9'h0);
      bus(1'b1, 8'h07, 32'h1, 9'h0);
      repeat (8) @(posedge core_clk);
      chk(9'h001, {8'h0, irqN});
      bus(1'b0, 8'h05, 32'h0, 9'h040);
      $display("test software reset done");
      summarize();
   end
endmodule
